// file: verilog/idp_cfg.svh
/*
  constants of the industrial digital i/o channel bank: register offsets, field
  positions, reset values and timing counts.
  assumes a 200 mhz system clock and a word-aligned ahb-lite register window.
*/
// Functional notes
// R1: sixteen channels, each set to input or output on its own.
// R2: all inputs sampled together at 200 kHz, one 14-bit converter each.
// R3: each sample compared with high and low thresholds to give pin state.
// R4: derived input state optionally debounced with a programmable delay.
// R5: high-side control at 1 turns high FET on, pin sources from supply.
// R6: low-side control at 1 turns low FET on, pin sinks to ground.
// R7: high and low controls of one channel never active together.
// R8: both controls off leaves the pin usable as a pure input.
// R9: open-circuit pull state: pull-up, pull-down, or both for half supply.
// R10: each channel holds its own PWM mode, frequency, duty and push/pull.
// R11: continuous mode keeps configured duty in every period.
// R12: soft start ramps duty from 0% up to the configured value.
// R13: soft stop ramps duty down to 0% when output commanded low.
// R14: PWM switches one transistor only, or both in push/pull.
// R15: push/pull inserts a dead gap between one FET off and other on.
// R16: duty settable zero to full scale with 16-bit resolution.
// R17: driven pin voltage read back through the channel's own converter.
// R18: ramps move duty by equal steps once per PWM period, per channel.
// R19: input channel forces both drive controls inactive.
`ifndef IDP_CFG_SVH
`define IDP_CFG_SVH

`define IDP_CLK_HZ 200000000
`define IDP_SAMPLE_HZ 200000
`define IDP_SAMPLE_CYCLES (`IDP_CLK_HZ / `IDP_SAMPLE_HZ)

`define IDP_REG_DEAD 10'h000
`define IDP_REG_STATE 10'h004
`define IDP_REG_RAW 10'h008
`define IDP_REG_DRIVE 10'h00c
`define IDP_REG_SCOUNT 10'h010
`define IDP_CH_BASE_BIT 9
`define IDP_CH_CFG 3'h0
`define IDP_CH_THR 3'h1
`define IDP_CH_PER 3'h2
`define IDP_CH_DUTY 3'h3
`define IDP_CH_STEP 3'h4
`define IDP_CH_DEB 3'h5
`define IDP_CH_CODE 3'h6

`define IDP_CFG_OUT 0
`define IDP_CFG_MODE 1
`define IDP_CFG_PP 3
`define IDP_CFG_LOWSIDE 4
`define IDP_CFG_HI 5
`define IDP_CFG_LO 6
`define IDP_CFG_PU 7
`define IDP_CFG_PD 8
`define IDP_CFG_DEB 9
`define IDP_THR_HI 16

`define IDP_DEAD_RST 8'h04
`define IDP_PER_RST 16'h4e20
`define IDP_THR_RST 32'h1000_0800

`endif

// file: verilog/idp_pkg.sv
/*
  types of the industrial digital i/o channel bank.
  assumes the constants header is included by every user.
*/
package idp_pkg;

  typedef enum logic [1:0] {
    IDP_MODE_STATIC = 2'b00,
    IDP_MODE_CONT = 2'b01,
    IDP_MODE_SSTART = 2'b10,
    IDP_MODE_SSTOP = 2'b11
  } idp_mode_t;

  typedef struct packed {
    logic is_out;
    idp_mode_t mode;
    logic push_pull;
    logic low_side;
    logic cmd_hi;
    logic cmd_lo;
  } idp_chan_cfg_t;

  typedef struct packed {
    logic [15:0] period;
    logic [15:0] duty;
    logic [15:0] step;
  } idp_pwm_set_t;

endpackage

// file: verilog/idp_pwm.sv
/*
  per-channel output driver: static drive, continuous, soft start and soft stop
  pwm, single or push/pull switching with a break-before-make gap.
  assumes settings are quasi-static flops from the register file.
*/
`timescale 1ns/1ps
`include "idp_cfg.svh"
module idp_pwm
  import idp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire idp_chan_cfg_t cfg_i,
  input wire idp_pwm_set_t set_i,
  input wire logic [7:0] dead_i,
  output logic hs_o,
  output logic ls_o
);
  logic [15:0] cnt_reg;
  logic [15:0] cur_reg;
  logic [15:0] cur_next;
  logic [7:0] dead_reg;
  logic hs_reg;
  logic ls_reg;
  wire logic [15:0] last = (set_i.period == 16'h0) ? 16'h0 : set_i.period - 16'h1;
  wire logic wrap = (cnt_reg >= last);
  wire logic cmd = cfg_i.cmd_hi;
  wire logic [16:0] up_sum = {1'b0, cur_reg} + {1'b0, set_i.step};
  wire logic [31:0] prod = cur_reg * set_i.period;
  wire logic phase = (cur_reg == 16'hffff) | (cnt_reg < prod[31:16]); // [R16]
  wire logic run = cmd | ((cfg_i.mode == IDP_MODE_SSTOP) & (cur_reg != 16'h0));
  wire logic is_pwm = (cfg_i.mode != IDP_MODE_STATIC);
  wire logic pw_hi = run & (cfg_i.push_pull ? phase : (phase & ~cfg_i.low_side)); // [R14]
  wire logic pw_lo = run & (cfg_i.push_pull ? ~phase : (phase & cfg_i.low_side));
  wire logic st_hi = cfg_i.cmd_hi & ~cfg_i.cmd_lo; // [R5] [R7]
  wire logic st_lo = cfg_i.cmd_lo & ~cfg_i.cmd_hi; // [R6] [R7]
  wire logic want_hi = cfg_i.is_out & (is_pwm ? pw_hi : st_hi); // [R19]
  wire logic want_lo = cfg_i.is_out & (is_pwm ? pw_lo : st_lo); // [R19]
  wire logic dead_zero = (dead_reg == 8'h0);
  wire logic turn_off = (hs_reg & ~want_hi) | (ls_reg & ~want_lo);

  // duty tracking: ramps step once per period, other modes every cycle
  always_comb begin
    cur_next = cur_reg;
    unique case (cfg_i.mode)
      IDP_MODE_STATIC: cur_next = 16'h0;
      IDP_MODE_CONT: cur_next = set_i.duty; // [R11]
      IDP_MODE_SSTART: begin
        if (!cmd) begin
          cur_next = 16'h0;
        end else if (wrap) begin
          cur_next = (up_sum >= {1'b0, set_i.duty}) ? set_i.duty : up_sum[15:0]; // [R12] [R18]
        end
      end
      IDP_MODE_SSTOP: begin
        if (cmd) begin
          cur_next = set_i.duty;
        end else if (wrap) begin
          cur_next = (cur_reg > set_i.step) ? cur_reg - set_i.step : 16'h0; // [R13] [R18]
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 16'h0;
      cur_reg <= 16'h0;
    end else begin
      cnt_reg <= wrap ? 16'h0 : cnt_reg + 16'h1; // [R10]
      cur_reg <= cur_next;
    end
  end

  // break-before-make: an off edge reloads the gap counter
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dead_reg <= 8'h0;
      hs_reg <= 1'b0;
      ls_reg <= 1'b0;
    end else begin
      dead_reg <= turn_off ? dead_i : (dead_zero ? 8'h0 : dead_reg - 8'h1); // [R15]
      hs_reg <= want_hi & ~want_lo & ~ls_reg & (hs_reg | dead_zero); // [R15] [R7]
      ls_reg <= want_lo & ~want_hi & ~hs_reg & (ls_reg | dead_zero); // [R15] [R7]
    end
  end

  assign hs_o = hs_reg;
  assign ls_o = ls_reg;
endmodule

// file: verilog/idp_top.sv
/*
  industrial digital i/o channel bank: ahb-lite register file, converter
  sample timing, threshold and debounce of inputs, per-channel output drivers.
  assumes one converter per channel, all started by one strobe and all
  returning their codes together with a one-cycle done pulse.
*/
`timescale 1ns/1ps
`include "idp_cfg.svh"
module idp_top
  import idp_pkg::*;
#(
  parameter int NUM_CH = 16,
  parameter int CODE_W = 14,
  parameter int SAMPLE_CYCLES = `IDP_SAMPLE_CYCLES
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  output logic adc_start_o,
  input wire logic adc_done_i,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] adc_code_i,
  output logic [NUM_CH-1:0] high_drive_o,
  output logic [NUM_CH-1:0] low_drive_o,
  output logic [NUM_CH-1:0] pull_up_o,
  output logic [NUM_CH-1:0] pull_down_o,
  output logic [NUM_CH-1:0] pin_state_o
);

  // parameter guards, refused while the design elaborates
  if (NUM_CH != 16) begin : g_bad_ch
    $error("idp_top serves exactly sixteen channels");
  end
  if (CODE_W < 1 || CODE_W > 16) begin : g_bad_code
    $error("idp_top converter width must be 1 to 16");
  end
  if (SAMPLE_CYCLES < 2 || SAMPLE_CYCLES > 65536) begin : g_bad_sample
    $error("idp_top sample interval out of range");
  end

  localparam logic [15:0] SAMPLE_LAST = 16'(SAMPLE_CYCLES - 1);

  // register decode helpers
  function automatic logic is_chan(input logic [9:0] a);
    return a[`IDP_CH_BASE_BIT];
  endfunction

  function automatic logic [2:0] chan_reg(input logic [9:0] a);
    return a[4:2];
  endfunction

  function automatic idp_chan_cfg_t to_cfg(input logic [31:0] r);
    idp_chan_cfg_t c;
    c.is_out = r[`IDP_CFG_OUT];
    c.mode = idp_mode_t'(r[`IDP_CFG_MODE+:2]);
    c.push_pull = r[`IDP_CFG_PP];
    c.low_side = r[`IDP_CFG_LOWSIDE];
    c.cmd_hi = r[`IDP_CFG_HI];
    c.cmd_lo = r[`IDP_CFG_LO];
    return c;
  endfunction

  // per-channel configuration storage
  logic [31:0] cfg_reg [16];
  logic [31:0] thr_reg [16];
  logic [15:0] per_reg [16];
  logic [15:0] duty_reg [16];
  logic [15:0] step_reg [16];
  logic [15:0] deb_reg [16];
  logic [CODE_W-1:0] code_reg [16];
  logic [7:0] dead_reg;

  // bus pipeline
  logic wr_pend_reg;
  logic [9:0] wr_addr_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // sampling and input state
  logic [15:0] tick_cnt_reg;
  logic start_reg;
  logic [31:0] scount_reg;
  logic [NUM_CH-1:0] raw_reg;
  logic [NUM_CH-1:0] state_reg;
  logic [15:0] deb_cnt_reg [16];
  logic [NUM_CH-1:0] hs_drv;
  logic [NUM_CH-1:0] ls_drv;
  logic [NUM_CH-1:0] hs_out_reg;
  logic [NUM_CH-1:0] ls_out_reg;

  // address phase decode
  wire logic addr_valid = hsel_i & hready_i & htrans_i[1];
  wire logic addr_write = addr_valid & hwrite_i;
  wire logic addr_read = addr_valid & ~hwrite_i;
  wire logic [9:0] a_word = {haddr_i[9:2], 2'b00};
  wire logic a_chan = is_chan(a_word);
  wire logic [3:0] a_ch = haddr_i[8:5];
  wire logic [2:0] a_reg = chan_reg(a_word);

  // data phase write decode
  wire logic w_chan = is_chan(wr_addr_reg);
  wire logic [3:0] w_ch = wr_addr_reg[8:5];
  wire logic [2:0] w_reg = chan_reg(wr_addr_reg);
  wire logic w_dead = wr_pend_reg & ~w_chan & (wr_addr_reg == `IDP_REG_DEAD);
  wire logic w_cfg = wr_pend_reg & w_chan & (w_reg == `IDP_CH_CFG);
  wire logic w_thr = wr_pend_reg & w_chan & (w_reg == `IDP_CH_THR);
  wire logic w_per = wr_pend_reg & w_chan & (w_reg == `IDP_CH_PER);
  wire logic w_duty = wr_pend_reg & w_chan & (w_reg == `IDP_CH_DUTY);
  wire logic w_step = wr_pend_reg & w_chan & (w_reg == `IDP_CH_STEP);
  wire logic w_deb = wr_pend_reg & w_chan & (w_reg == `IDP_CH_DEB);

  // read selection
  wire logic [31:0] cfg_rd = cfg_reg[a_ch] & 32'h0000_03ff;
  wire logic [31:0] code_rd = {{(32-CODE_W){1'b0}}, code_reg[a_ch]};
  wire logic [31:0] thr_rd = thr_reg[a_ch];

  always_comb begin
    rdata_next = 32'h0;
    if (a_chan) begin
      unique case (a_reg)
        `IDP_CH_CFG: rdata_next = cfg_rd;
        `IDP_CH_THR: rdata_next = thr_rd;
        `IDP_CH_PER: rdata_next = {16'h0, per_reg[a_ch]};
        `IDP_CH_DUTY: rdata_next = {16'h0, duty_reg[a_ch]};
        `IDP_CH_STEP: rdata_next = {16'h0, step_reg[a_ch]};
        `IDP_CH_DEB: rdata_next = {16'h0, deb_reg[a_ch]};
        `IDP_CH_CODE: rdata_next = code_rd; // [R17]
        default: rdata_next = 32'h0;
      endcase
    end else begin
      unique case (a_word)
        `IDP_REG_DEAD: rdata_next = {24'h0, dead_reg};
        `IDP_REG_STATE: rdata_next = {16'h0, state_reg};
        `IDP_REG_RAW: rdata_next = {16'h0, raw_reg};
        `IDP_REG_DRIVE: rdata_next = {ls_out_reg, hs_out_reg};
        `IDP_REG_SCOUNT: rdata_next = scount_reg;
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 10'h0;
      rdata_reg <= 32'h0;
    end else begin
      if (hready_i) begin
        wr_pend_reg <= addr_write;
        wr_addr_reg <= a_word;
      end
      if (addr_read) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // zero-wait slave, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_reg;

  // global registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dead_reg <= `IDP_DEAD_RST;
    end else if (w_dead) begin
      dead_reg <= hwdata_i[7:0];
    end
  end

  // per-channel registers, each channel written on its own
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        cfg_reg[i] <= 32'h0;
      end
    end else if (w_cfg) begin
      cfg_reg[w_ch] <= hwdata_i & 32'h0000_03ff; // [R1]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        thr_reg[i] <= `IDP_THR_RST;
      end
    end else if (w_thr) begin
      thr_reg[w_ch] <= hwdata_i; // [R3]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        per_reg[i] <= `IDP_PER_RST;
      end
    end else if (w_per) begin
      per_reg[w_ch] <= hwdata_i[15:0]; // [R10]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        duty_reg[i] <= 16'h0;
      end
    end else if (w_duty) begin
      duty_reg[w_ch] <= hwdata_i[15:0]; // [R16]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        step_reg[i] <= 16'h0;
      end
    end else if (w_step) begin
      step_reg[w_ch] <= hwdata_i[15:0]; // [R18]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        deb_reg[i] <= 16'h0;
      end
    end else if (w_deb) begin
      deb_reg[w_ch] <= hwdata_i[15:0]; // [R4]
    end
  end

  // common conversion start for all channels
  wire logic tick = (tick_cnt_reg >= SAMPLE_LAST);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 16'h0;
      start_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick ? 16'h0 : tick_cnt_reg + 16'h1;
      start_reg <= tick; // [R2]
    end
  end

  assign adc_start_o = start_reg;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scount_reg <= 32'h0;
    end else if (adc_done_i) begin
      scount_reg <= scount_reg + 32'h1;
    end
  end

  // per-channel input path and output driver
  for (genvar g = 0; g < 16; g++) begin : g_ch
    wire logic [CODE_W-1:0] thr_hi = thr_reg[g][`IDP_THR_HI+:CODE_W];
    wire logic [CODE_W-1:0] thr_lo = thr_reg[g][CODE_W-1:0];
    wire logic [CODE_W-1:0] code = adc_code_i[g];
    wire logic above = (code >= thr_hi);
    wire logic below = (code <= thr_lo);
    wire logic raw_next = above ? 1'b1 : (below ? 1'b0 : raw_reg[g]);
    wire logic deb_on = cfg_reg[g][`IDP_CFG_DEB];
    wire logic differs = (raw_next != state_reg[g]);
    wire logic deb_done = ((deb_cnt_reg[g] + 16'h1) >= deb_reg[g]);
    wire idp_chan_cfg_t ch_cfg = to_cfg(cfg_reg[g]);
    wire idp_pwm_set_t ch_set = '{period: per_reg[g], duty: duty_reg[g], step: step_reg[g]};

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        code_reg[g] <= '0;
        raw_reg[g] <= 1'b0;
      end else if (adc_done_i) begin
        code_reg[g] <= code; // [R17]
        raw_reg[g] <= raw_next; // [R3]
      end
    end

    // with debounce on, state follows a new level only after it held for the set sample count
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        deb_cnt_reg[g] <= 16'h0;
        state_reg[g] <= 1'b0;
      end else if (adc_done_i) begin
        if (!differs) begin
          deb_cnt_reg[g] <= 16'h0;
        end else if (!deb_on || deb_done) begin
          deb_cnt_reg[g] <= 16'h0;
          state_reg[g] <= raw_next; // [R4]
        end else begin
          deb_cnt_reg[g] <= deb_cnt_reg[g] + 16'h1;
        end
      end
    end

    idp_pwm u_pwm (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .cfg_i(ch_cfg),
      .set_i(ch_set),
      .dead_i(dead_reg),
      .hs_o(hs_drv[g]),
      .ls_o(ls_drv[g])
    );

    assign pull_up_o[g] = cfg_reg[g][`IDP_CFG_PU]; // [R9]
    assign pull_down_o[g] = cfg_reg[g][`IDP_CFG_PD]; // [R9]
  end

  // final interlock and direction gate on the fet controls
  wire logic [NUM_CH-1:0] dir_out = {
    cfg_reg[15][0], cfg_reg[14][0], cfg_reg[13][0], cfg_reg[12][0],
    cfg_reg[11][0], cfg_reg[10][0], cfg_reg[9][0], cfg_reg[8][0],
    cfg_reg[7][0], cfg_reg[6][0], cfg_reg[5][0], cfg_reg[4][0],
    cfg_reg[3][0], cfg_reg[2][0], cfg_reg[1][0], cfg_reg[0][0]
  };
  wire logic [NUM_CH-1:0] hs_safe = hs_drv & ~ls_drv & dir_out; // [R7] [R19]
  wire logic [NUM_CH-1:0] ls_safe = ls_drv & ~hs_drv & dir_out; // [R7] [R19]

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_out_reg <= '0;
      ls_out_reg <= '0;
    end else begin
      hs_out_reg <= hs_safe; // [R5]
      ls_out_reg <= ls_safe; // [R6]
    end
  end

  // both controls low leaves the pin to the input path
  assign high_drive_o = hs_out_reg; // [R8]
  assign low_drive_o = ls_out_reg;
  assign pin_state_o = state_reg;

endmodule

// file: verif/idp_checker.sv
/*
  port checker of the industrial digital i/o channel bank.
  assumes it is bound into idp_top, one clock, active-high asynchronous reset.
*/
`timescale 1ns/1ps
module idp_checker
  import idp_pkg::*;
#(
  parameter int NUM_CH = 16,
  parameter int SAMPLE_CYCLES = 1000
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic hready_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic adc_start_o,
  input wire logic adc_done_i,
  input wire logic [NUM_CH-1:0] high_drive_o,
  input wire logic [NUM_CH-1:0] low_drive_o,
  input wire logic [NUM_CH-1:0] pin_state_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  int gap_cnt_reg;
  logic seen_reg;
  wire rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  // cycles since the last conversion start
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_cnt_reg <= 0;
      seen_reg <= 1'b0;
    end else if (adc_start_o) begin
      gap_cnt_reg <= 0;
      seen_reg <= 1'b1;
    end else begin
      gap_cnt_reg <= gap_cnt_reg + 1;
    end
  end
  property p_no_overlap;
    (high_drive_o & low_drive_o) == '0;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both fets on");
  property p_gap_hl;
    ($past(high_drive_o) & low_drive_o) == '0;
  endproperty
  a_gap_hl: assert property (p_gap_hl) else $error("no gap high to low");
  property p_gap_lh;
    ($past(low_drive_o) & high_drive_o) == '0;
  endproperty
  a_gap_lh: assert property (p_gap_lh) else $error("no gap low to high");
  property p_start_pulse;
    adc_start_o |=> !adc_start_o [*8];
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_start_period;
    adc_start_o && seen_reg |-> gap_cnt_reg == SAMPLE_CYCLES - 1;
  endproperty
  a_start_period: assert property (p_start_period) else $error("sample period");
  property p_state_on_sample;
    !$past(adc_done_i) |-> $stable(pin_state_o);
  endproperty
  a_state_on_sample: assert property (p_state_on_sample) else $error("state moved");
  property p_rdata_holds;
    !$past(rd_take) |-> $stable(hrdata_o);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");
  property p_okay;
    hreadyout_o && !hresp_o;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or error");
  c_high: cover property (high_drive_o != '0);
  c_low: cover property (low_drive_o != '0);
  c_done: cover property (adc_done_i);
endmodule

bind idp_top idp_checker #(.NUM_CH(NUM_CH), .SAMPLE_CYCLES(SAMPLE_CYCLES)) idp_checker_inst (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .hready_i(hready_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .hrdata_o(hrdata_o), .adc_start_o(adc_start_o),
  .adc_done_i(adc_done_i), .high_drive_o(high_drive_o), .low_drive_o(low_drive_o),
  .pin_state_o(pin_state_o));

// file: verif/idp_field.sv
/*
  field side model: sixteen converters started together, codes from set levels.
  assumes one start pulse per sample and a latency chosen by the bench.
*/
`timescale 1ns/1ps
module idp_field
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic adc_start_i,
  input wire logic [3:0] lat_i,
  input wire logic [15:0][13:0] level_i,
  output logic adc_done_o,
  output logic [15:0][13:0] adc_code_o
);
  logic [3:0] wait_reg;
  logic busy_reg;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      wait_reg <= 4'h0;
      adc_done_o <= 1'b0;
      adc_code_o <= '0;
    end else begin
      adc_done_o <= 1'b0;
      // codes are junk outside the done cycle
      adc_code_o <= ~adc_code_o;
      if (adc_start_i) begin
        busy_reg <= 1'b1;
        wait_reg <= lat_i;
      end else if (busy_reg && wait_reg <= 4'h1) begin
        // all channels converted at once
        busy_reg <= 1'b0;
        adc_done_o <= 1'b1;
        adc_code_o <= level_i;
      end else if (busy_reg) begin
        wait_reg <= wait_reg - 4'h1;
      end
    end
  end
endmodule

// file: verif/industrial_dio_channel_pwm_tb.sv
/*
  self-checking bench of the industrial digital i/o channel bank.
  assumes zero-wait ahb-lite slave and the field model on the converter side.
*/
`timescale 1ns/1ps
module industrial_dio_channel_pwm_tb;
  import idp_pkg::*;
  localparam int SC = 20;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic hreadyout, hresp, adc_start, adc_done;
  logic [31:0] hrdata;
  logic [15:0][13:0] code;
  logic [15:0][13:0] level = '0;
  logic [3:0] lat = 4'h1;
  logic [15:0] hi_d, lo_d, pu, pd, pst;
  int n_mismatch = 0;
  int checks = 0;
  int hc [16];
  int lc [16];
  logic [31:0] scfg [4] = '{32'ha1, 32'h141, 32'h1a0, 32'h61};
  logic [31:0] dty [7] = '{32'h8000, 32'h8000, 32'h8000, 32'hffff, 32'h0, 32'h8000, 32'h8000};
  logic [31:0] pcfg [7] = '{32'h23, 32'h33, 32'h2b, 32'h23, 32'h23, 32'h05, 32'h27};
  int eh [7] = '{50, 0, 35, 100, 0, 0, 50};
  int el [7] = '{0, 50, 35, 0, 0, 0, 0};
  always #2.5 sys_clk_i = ~sys_clk_i;
  idp_top #(.SAMPLE_CYCLES(SC)) idp_top_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
    .adc_start_o(adc_start), .adc_done_i(adc_done), .adc_code_i(code),
    .high_drive_o(hi_d), .low_drive_o(lo_d), .pull_up_o(pu), .pull_down_o(pd),
    .pin_state_o(pst));
  idp_field idp_field_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .adc_start_i(adc_start), .lat_i(lat),
    .level_i(level), .adc_done_o(adc_done), .adc_code_o(code));
  function automatic logic [31:0] ca(input int ch, input int off);
    return 32'h200 + 32'(ch) * 32'h20 + 32'(off);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdy();
    @(posedge sys_clk_i);
    while (hreadyout !== 1'b1) @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    rdy();
    chk(hrdata, e);
  endtask
  task automatic meas(input int n);
    hc = '{default: 0};
    lc = '{default: 0};
    repeat (n) begin
      @(posedge sys_clk_i);
      for (int i = 0; i < 16; i++) begin
        hc[i] += int'(hi_d[i] === 1'b1);
        lc[i] += int'(lo_d[i] === 1'b1);
      end
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rdc(32'h000, 32'h4);
    rdc(ca(0, 4), 32'h1000_0800);
    rdc(ca(3, 8), 32'h4e20);
    wr(32'h014, 32'hffff_ffff);
    rdc(32'h014, 32'h0);
    wr(32'h004, 32'hffff);
    rdc(32'h004, 32'h0);
    // static drive, direction and pulls on channels 0..3
    for (int i = 0; i < 4; i++) wr(ca(i, 0), scfg[i]);
    repeat (4) @(posedge sys_clk_i);
    chk({16'h0, hi_d}, 32'h1);
    chk({16'h0, lo_d}, 32'h2);
    chk({pu, pd}, 32'h0005_0006);
    rdc(32'h00c, 32'h0002_0001);
    wr(ca(0, 0), 32'h41);
    repeat (20) @(posedge sys_clk_i);
    chk({hi_d, lo_d}, 32'h3);
    // thresholds, debounce and code readback, slow converter
    lat <= 4'h8;
    wr(ca(5, 0), 32'h200);
    wr(ca(5, 20), 32'h3);
    level[4] <= 14'h1000;
    level[5] <= 14'h1000;
    repeat (2 * SC) @(posedge sys_clk_i);
    chk({30'h0, pst[5:4]}, 32'h1);
    repeat (3 * SC) @(posedge sys_clk_i);
    chk({30'h0, pst[5:4]}, 32'h3);
    level[4] <= 14'h0900;
    repeat (2 * SC) @(posedge sys_clk_i);
    chk({31'h0, pst[4]}, 32'h1);
    rdc(ca(4, 24), 32'h900);
    level[4] <= 14'h0800;
    repeat (2 * SC) @(posedge sys_clk_i);
    chk({31'h0, pst[4]}, 32'h0);
    // pwm on channels 6..12
    lat <= 4'h1;
    wr(32'h000, 32'h2);
    for (int i = 6; i <= 12; i++) begin
      wr(ca(i, 8), i == 8 ? 32'd20 : 32'd10);
      wr(ca(i, 12), dty[i-6]);
      wr(ca(i, 16), 32'h2000);
      wr(ca(i, 0), pcfg[i-6]);
    end
    repeat (60) @(posedge sys_clk_i);
    meas(100);
    for (int i = 6; i <= 12; i++) begin
      chk(32'(hc[i]), 32'(eh[i-6]));
      chk(32'(lc[i]), 32'(el[i-6]));
    end
    wr(ca(11, 0), 32'h25);
    wr(ca(12, 0), 32'h07);
    meas(40);
    chk({31'h0, hc[11] > 0 && hc[11] < 20}, 32'h1);
    chk({31'h0, hc[12] > 0 && hc[12] < 20}, 32'h1);
    repeat (100) @(posedge sys_clk_i);
    meas(20);
    chk(32'(hc[11]), 32'd10);
    chk(32'(hc[12]), 32'd0);
    results();
  end
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule
